/* File: design/low_power_mode_controller.sv */
// Purpose: sequences stop entry, stop exit with S1_EXITSEL clear, and idle1/2, sleep1/2 and idle0/sleep0 entry and exit
// Assumes: CPU fetch and interrupt controller outside; pins synchronous to mclk
// Notes:   warm-up counted by a divider from mclk; count parameters shorten simulation
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "lpm_regs.svh"
module low_power_mode_controller #(
    // Odd codes run a third of the even code below them
    parameter int unsigned WARM_N0 = `WU_N0_US * `CLK_MHZ,
    parameter int unsigned WARM_N1 = WARM_N0 / 3,
    parameter int unsigned WARM_N2 = `WU_N2_US * `CLK_MHZ,
    parameter int unsigned WARM_N3 = WARM_N2 / 3,
    parameter int unsigned WARM_S0 = `WU_S0_US * `CLK_MHZ,
    parameter int unsigned WARM_S1 = WARM_S0 / 3,
    parameter int unsigned WARM_S2 = `WU_S2_US * `CLK_MHZ,
    parameter int unsigned WARM_S3 = WARM_S2 / 3
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        stopPin,
    input  wire logic        wakeRequest,
    input  wire logic        watchdogIrq,
    input  wire logic        timebaseSource,
    output logic             cpuHalt,
    output logic             watchdogHalt,
    output logic             peripheralClockGate,
    output logic             highOscEnable,
    output logic             lowOscEnable,
    output logic             resumePulse,
    output logic             serviceRequest,
    output logic             timebaseInterrupt,
    output logic             dividerClear
);
    logic [7:0]        system_control_one;
    logic [7:0]        system_control_two;
    logic [7:0]        wakeup_key_control_reg;
    logic [7:0]        timebase_control_reg;
    logic [7:0]        intCtl;
    lpm_pkg::mode_type mode;
    logic [31:0]       prescaler;
    logic              stopPinLast;
    logic              tbLast;
    logic              ack;
    logic              wrStb;
    logic              stopRise;
    logic              tbFall;
    logic              halt0Exit;
    logic              idleExit;
    logic              warmDone;
    logic              allThree;
    logic [31:0]       warmTarget;

    function automatic logic [31:0] pick_warm(input logic [1:0] sel, input logic slow,
                                              input logic div1);
        logic [31:0] t;
        t = 32'h0;
        if (slow)
        begin
            case (sel)
                2'b00:   t = WARM_S0;
                2'b01:   t = WARM_S1;
                2'b10:   t = WARM_S2;
                default: t = WARM_S3;
            endcase
        end
        else
        begin
            case (sel)
                2'b00:   t = WARM_N0;
                2'b01:   t = WARM_N1;
                2'b10:   t = WARM_N2;
                default: t = WARM_N3;
            endcase
            if (div1)
                t = {t[30:0], 1'b0};
        end
        return t;
    endfunction : pick_warm

    // Oscillators restarted on stop exit, high then low
    function automatic logic [1:0] restart_osc(input logic slow, input logic dual);
        logic [1:0] r;
        r = 2'b10;
        if (dual)
            r = slow ? 2'b01 : 2'b11;
        return r;
    endfunction : restart_osc

    function automatic logic wr_hit(input logic stb, input logic [7:0] a,
                                    input logic [7:0] ofs);
        return stb && (a == ofs);
    endfunction : wr_hit

    // One wait state: every access is answered on the second edge
    assign waitrequest = (read | write) & ~ack;
    assign wrStb       = write & ack;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ack <= 1'b0;
        else
            ack <= (read | write) & ~ack;
    end

    always_ff @(posedge mclk)
    begin
        // Read data is taken on the first cycle and stands at the answering edge
        if (!rst_n)
            readdata <= 32'h0;
        else if (read & ~ack)
        begin
            case (address)
                `SYSCTL1_OFS: readdata <= {24'h0, system_control_one[7:2], 2'b00};
                `SYSCTL2_OFS: readdata <= {24'h0, system_control_two[7:4], 1'b0,
                                           system_control_two[2], 2'b00};
                `WAKEKEY_OFS: readdata <= {24'h0, wakeup_key_control_reg};
                `TBCTL_OFS:   readdata <= {24'h0, timebase_control_reg};
                `INTCTL_OFS:  readdata <= {24'h0, intCtl};
                `STATUS_OFS:  readdata <= {29'h0, mode};
                default:      readdata <= 32'h0;
            endcase
        end
    end

    assign stopRise  = stopPin & ~stopPinLast;
    assign tbFall    = ~timebaseSource & tbLast;
    assign halt0Exit = (mode == lpm_pkg::HALT0_ST) && tbFall;
    assign idleExit  = (mode == lpm_pkg::IDLE_ST) && wakeRequest;
    assign warmDone  = (mode == lpm_pkg::WARM_ST) && (prescaler >= warmTarget);
    // Timebase service needs master, individual and timer enables together
    assign allThree  = intCtl[`IC_IMF] & intCtl[`IC_EFTB] & timebase_control_reg[`TB_EN];

    always_ff @(posedge mclk)
    begin
        // Stop pin idles high, so reset must not fake a rise
        stopPinLast <= rst_n ? stopPin : 1'b1;
        tbLast      <= rst_n ? timebaseSource : 1'b0;
    end

    // Reset pin drops every mode straight back to run, normal1 register values
    // With idle and halt both set, idle goes first and halt follows its exit
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            mode <= lpm_pkg::RUN_ST;
        else
        begin
            case (mode)
                lpm_pkg::RUN_ST:
                begin
                    if (system_control_one[`S1_STOP])
                        mode <= lpm_pkg::STOP_ST;
                    else if (system_control_two[`S2_IDLE] && !watchdogIrq)
                        mode <= lpm_pkg::IDLE_ST;
                    else if (system_control_two[`S2_GENERATOR_HALT_BIT])
                        mode <= lpm_pkg::HALT0_ST;
                end
                lpm_pkg::STOP_ST:
                begin
                    if (!system_control_one[`S1_EXITSEL] && stopRise)
                        mode <= lpm_pkg::WARM_ST;
                end
                lpm_pkg::WARM_ST:
                begin
                    if (warmDone)
                        mode <= lpm_pkg::RUN_ST;
                end
                lpm_pkg::IDLE_ST:
                begin
                    if (idleExit)
                        mode <= lpm_pkg::RUN_ST;
                end
                lpm_pkg::HALT0_ST:
                begin
                    if (halt0Exit)
                        mode <= lpm_pkg::RUN_ST;
                end
                default: mode <= lpm_pkg::RUN_ST;
            endcase
        end
    end

    // Warm-up counted on the divider chain, which restarts from zero at exit
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            prescaler <= 32'h0;
        else if (mode == lpm_pkg::STOP_ST)
            prescaler <= 32'h0;
        else
            prescaler <= prescaler + 32'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            warmTarget <= 32'h1;
        // Latched while stopped so a write during warm-up cannot move it
        else if (mode == lpm_pkg::STOP_ST)
            warmTarget <= pick_warm(system_control_one[`S1_WUT_HI:`S1_WUT_LO],
                                    system_control_one[`S1_RETSLOW],
                                    intCtl[`IC_DIV1]);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            system_control_one <= `S1_RESET;
        // Stop bit drops at the end of warm-up, ahead of a same-cycle write
        else if (warmDone)
            system_control_one[`S1_STOP] <= 1'b0;
        else if (wr_hit(wrStb, address, `SYSCTL1_OFS))
            system_control_one <= writedata[7:0];
    end

    // Hardware clear of idle and halt bits wins over a same-cycle write
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            system_control_two <= `S2_RESET;
        else if (idleExit || (mode == lpm_pkg::RUN_ST && system_control_two[`S2_IDLE]
                              && watchdogIrq))
            system_control_two[`S2_IDLE] <= 1'b0;
        else if (halt0Exit)
            system_control_two[`S2_GENERATOR_HALT_BIT] <= 1'b0;
        else if (warmDone)
        begin
            // The oscillators left running after stop exit are those restarted
            {system_control_two[`S2_XEN], system_control_two[`S2_XTEN]} <=
                restart_osc(system_control_one[`S1_RETSLOW], intCtl[`IC_DUAL]);
        end
        else if (wr_hit(wrStb, address, `SYSCTL2_OFS))
            system_control_two <= writedata[7:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wakeup_key_control_reg <= 8'h00;
            timebase_control_reg   <= `TB_RESET;
            intCtl                 <= `IC_RESET;
        end
        else if (wrStb)
        begin
            case (address)
                `WAKEKEY_OFS: wakeup_key_control_reg <= writedata[7:0];
                `TBCTL_OFS:   timebase_control_reg   <= writedata[7:0];
                `INTCTL_OFS:  intCtl                 <= writedata[7:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            resumePulse       <= 1'b0;
            serviceRequest    <= 1'b0;
            timebaseInterrupt <= 1'b0;
            dividerClear      <= 1'b0;
        end
        else
        begin
            resumePulse       <= warmDone || (idleExit && !intCtl[`IC_IMF])
                                 || (halt0Exit && (!allThree || intCtl[`IC_L8SEL]));
            serviceRequest    <= (idleExit && intCtl[`IC_IMF])
                                 || (halt0Exit && allThree && !intCtl[`IC_L8SEL]);
            timebaseInterrupt <= halt0Exit && timebase_control_reg[`TB_EN];
            dividerClear      <= (mode == lpm_pkg::STOP_ST) && (stopRise
                                 && !system_control_one[`S1_EXITSEL]);
        end
    end

    // Stop: all halted; idle: CPU and watchdog only; halt0: peripherals gated too
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cpuHalt             <= 1'b0;
            watchdogHalt        <= 1'b0;
            peripheralClockGate <= 1'b0;
            highOscEnable       <= 1'b1;
            lowOscEnable        <= 1'b0;
        end
        else
        begin
            cpuHalt             <= (mode != lpm_pkg::RUN_ST);
            watchdogHalt        <= (mode != lpm_pkg::RUN_ST);
            peripheralClockGate <= (mode == lpm_pkg::STOP_ST) || (mode == lpm_pkg::WARM_ST)
                                   || (mode == lpm_pkg::HALT0_ST);
            if (mode == lpm_pkg::STOP_ST)
            begin
                highOscEnable <= 1'b0;
                lowOscEnable  <= 1'b0;
            end
            else if (mode == lpm_pkg::WARM_ST)
            begin
                {highOscEnable, lowOscEnable} <= restart_osc(system_control_one[`S1_RETSLOW],
                                                             intCtl[`IC_DUAL]);
            end
            else
            begin
                highOscEnable <= system_control_two[`S2_XEN];
                lowOscEnable  <= system_control_two[`S2_XTEN];
            end
        end
    end
endmodule : low_power_mode_controller

/* File: design/lpm_regs.svh */
// Purpose: offsets, field positions, reset values and timing for the low-power controller
// Assumes: Avalon-MM word addressing as byte offsets, 32-bit data
// Notes:   warm-up figures are in microseconds at the nominal oscillator rates
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

`define SYSCTL1_OFS      8'h00
`define SYSCTL2_OFS      8'h04
`define WAKEKEY_OFS      8'h08
`define TBCTL_OFS        8'h0c
`define INTCTL_OFS       8'h10
`define STATUS_OFS       8'h14

// system_control_one
`define S1_STOP          7
`define S1_EXITSEL       6
`define S1_RETSLOW       5
`define S1_WUT_HI        3
`define S1_WUT_LO        2
`define S1_RESET         8'h00
// system_control_two
`define S2_XEN           7
`define S2_XTEN          6
`define S2_SYSCK         5
`define S2_IDLE          4
`define S2_GENERATOR_HALT_BIT        2
`define S2_RESET         8'h80
// interrupt control register: master, individual enables, latch-8 selector, divide and dual bits; then timebase control enable
`define IC_IMF           0
`define IC_EFTB          1
`define IC_EFWAKE        2
`define IC_L8SEL         3
`define IC_DIV1          4
`define IC_DUAL          5
`define IC_RESET         8'h00
`define TB_EN            7
`define TB_RESET         8'h00

// Warm-up times, microseconds, for normal return with divide bit zero and slow return
`define WU_N0_US         12288
`define WU_N1_US         4096
`define WU_N2_US         3072
`define WU_N3_US         1024
`define WU_S0_US         750000
`define WU_S1_US         250000
`define WU_S2_US         5850
`define WU_S3_US         1950
`define CLK_MHZ          200
`endif

/* File: design/lpm_pkg.sv */
// Purpose: types of the low-power controller
// Assumes: nothing
// Notes:   mode codes are binary and fixed
package lpm_pkg;
    typedef enum logic [2:0] {
        RUN_ST    = 3'b000,
        STOP_ST   = 3'b001,
        WARM_ST   = 3'b010,
        IDLE_ST   = 3'b011,
        HALT0_ST  = 3'b100
    } mode_type;
endpackage : lpm_pkg

/* File: tb/lpm_checker_properties.sv */
// Purpose: port-level properties of the low-power mode controller
// Assumes: one clock, synchronous active-low reset
// Notes:   edge ages saturate at 15 so they never wrap into a false match
`timescale 1ns/1ps
module lpm_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic stopPin,
    input wire logic timebaseSource,
    input wire logic cpuHalt,
    input wire logic watchdogHalt,
    input wire logic peripheralClockGate,
    input wire logic highOscEnable,
    input wire logic lowOscEnable,
    input wire logic resumePulse,
    input wire logic serviceRequest,
    input wire logic timebaseInterrupt,
    input wire logic dividerClear
);
    logic       stPrev;
    logic       tbPrev;
    logic [3:0] stAge;
    logic [3:0] tbAge;

    always_ff @(posedge mclk)
    begin
        stPrev <= stopPin;
        tbPrev <= timebaseSource;
        if (!rst_n)
        begin
            stAge <= 4'hf;
            tbAge <= 4'hf;
        end
        else
        begin
            stAge <= (stopPin && !stPrev) ? 4'h0 : ((stAge == 4'hf) ? stAge : stAge + 4'h1);
            tbAge <= (!timebaseSource && tbPrev) ? 4'h0 : ((tbAge == 4'hf) ? tbAge : tbAge + 4'h1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_reset_normal1;
        $rose(rst_n) |-> !cpuHalt && highOscEnable && !lowOscEnable && !resumePulse;
    endproperty
    a_reset_normal1: assert property (p_reset_normal1)
        else $error("outputs not in normal1 after reset");
    property p_resume_single;
        resumePulse |=> !resumePulse;
    endproperty
    a_resume_single: assert property (p_resume_single)
        else $error("resume pulse longer than one cycle");
    property p_service_excl;
        serviceRequest |-> !resumePulse ##1 !serviceRequest;
    endproperty
    a_service_excl: assert property (p_service_excl)
        else $error("service and resume together");
    property p_watchdog_halt;
        watchdogHalt |-> cpuHalt;
    endproperty
    a_watchdog_halt: assert property (p_watchdog_halt)
        else $error("watchdog halted while cpu runs");
    property p_gate_halt;
        peripheralClockGate |-> cpuHalt;
    endproperty
    a_gate_halt: assert property (p_gate_halt)
        else $error("peripheral clocks gated while cpu runs");
    property p_timebase_edge;
        timebaseInterrupt |-> tbAge <= 4'h4;
    endproperty
    a_timebase_edge: assert property (p_timebase_edge)
        else $error("timebase latch set without a falling source edge");
    property p_osc_edge;
        $rose(highOscEnable) || $rose(lowOscEnable) |-> stAge <= 4'h4;
    endproperty
    a_osc_edge: assert property (p_osc_edge)
        else $error("oscillator restart without a stop pin rise");
    property p_divider_single;
        dividerClear |=> !dividerClear;
    endproperty
    a_divider_single: assert property (p_divider_single)
        else $error("divider clear longer than one cycle");

    c_service: cover property (serviceRequest);
    c_timebase: cover property (timebaseInterrupt);
    c_divider: cover property (dividerClear);
endmodule : lpm_checker

bind low_power_mode_controller lpm_checker chk (.mclk, .rst_n, .stopPin, .timebaseSource,
    .cpuHalt, .watchdogHalt, .peripheralClockGate, .highOscEnable, .lowOscEnable,
    .resumePulse, .serviceRequest, .timebaseInterrupt, .dividerClear);

/* File: tb/wake_partner.sv */
// Purpose: stop pin, wake latch and timebase source of the surrounding chip
// Assumes: go is a one-cycle strobe, kind 0 stop pin, 1 wake, 2 timebase
// Notes:   each event lasts six cycles, then the line goes back to its idle level
`timescale 1ns/1ps
module wake_partner (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       go,
    input wire logic [1:0] kind,
    output logic           stopPin,
    output logic           wakeRequest,
    output logic           timebaseSource
);
    int unsigned left;

    always_ff @(posedge mclk)
    begin
        if (!rst_n || left == 1)
        begin
            stopPin        <= 1'b1;
            wakeRequest    <= 1'b0;
            timebaseSource <= 1'b1;
            left           <= 0;
        end
        else if (go)
        begin
            stopPin        <= (kind != 2'h0);
            wakeRequest    <= (kind == 2'h1);
            timebaseSource <= (kind != 2'h2);
            left           <= 6;
        end
        else if (left != 0)
            left <= left - 1;
    end
endmodule : wake_partner

/* File: tb/tb.sv */
// Purpose: self-checking bench of the low-power mode controller
// Assumes: one wait state on every register access
// Notes:   warm-up counts are shortened through the parameters
`timescale 1ns/1ps
`include "lpm_regs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        watchdogIrq = 1'b0;
    logic        go = 1'b0;
    logic        stPrev = 1'b1;
    logic [1:0]  kind = 2'h0;
    logic [1:0]  oscWarm;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] rd;
    logic [31:0] readdata;
    logic        waitrequest, stopPin, wakeRequest, timebaseSource, cpuHalt, watchdogHalt;
    logic        peripheralClockGate, highOscEnable, lowOscEnable, resumePulse;
    logic        serviceRequest, timebaseInterrupt, dividerClear;
    int          n_errors = 0, check_count = 0, seed = 31581, cyc = 0, riseCyc = 0, endCyc = 0;
    int          nRes = 0, nSvc = 0, nTb = 0, nDiv = 0;
    int          warm[12] = '{48, 16, 24, 8, 96, 32, 48, 16, 60, 20, 30, 10};

    always #2.5 mclk = ~mclk;

    // Odd warm-up codes follow from the even ones at a third
    low_power_mode_controller #(.WARM_N0(48), .WARM_N2(24), .WARM_S0(60), .WARM_S2(30))
        dut (.mclk, .rst_n, .address,
        .read, .write, .writedata, .readdata, .waitrequest, .stopPin, .wakeRequest,
        .watchdogIrq, .timebaseSource, .cpuHalt, .watchdogHalt, .peripheralClockGate,
        .highOscEnable, .lowOscEnable, .resumePulse, .serviceRequest, .timebaseInterrupt,
        .dividerClear);
    wake_partner partner (.mclk, .rst_n, .go, .kind, .stopPin, .wakeRequest, .timebaseSource);

    always @(posedge mclk)
    begin
        cyc++;
        if (stopPin === 1'b1 && stPrev === 1'b0) riseCyc = cyc;
        stPrev = stopPin;
        if (resumePulse === 1'b1)
        begin
            endCyc = cyc;
            oscWarm = {highOscEnable, lowOscEnable};
        end
        nRes += (resumePulse === 1'b1);
        nSvc += (serviceRequest === 1'b1);
        nTb += (timebaseInterrupt === 1'b1);
        nDiv += (dividerClear === 1'b1);
    end

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        if (waitrequest !== 1'b0)
        begin
            n_errors++;
            conclude();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic status(input int ex);
        bus(0, `STATUS_OFS, 0);
        `CHK("mode", ex, rd[2:0])
    endtask : status

    // Random spacing keeps events from lining up with the bus traffic
    task automatic kick(input logic [1:0] k);
        int n;
        n = $unsigned($random(seed)) % 5;
        repeat (n) @(posedge mclk);
        kind <= k;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask : kick

    task automatic waitEnd(input int base);
        int k;
        k = 0;
        while (nRes + nSvc == base && k < 1000)
        begin
            @(posedge mclk);
            k++;
        end
        if (nRes + nSvc == base)
        begin
            n_errors++;
            conclude();
        end
    endtask : waitEnd

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        conclude();
    end

    initial
    begin
        int s;
        int r;
        int b;
        int sel;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(0, `SYSCTL2_OFS, 0);
        `CHK("sysctl2", `S2_RESET, rd[7:0])
        bus(1, 8'h20, $random(seed));
        bus(0, 8'h20, 0);
        `CHK("unmapped", 0, rd)
        bus(1, `WAKEKEY_OFS, 0);
        for (int i = 0; i < 12; i++)
        begin
            sel = i / 4;
            bus(1, `INTCTL_OFS, ((sel == 1) << `IC_DIV1) | ((sel != 0) << `IC_DUAL));
            bus(1, `SYSCTL1_OFS, 8'h80 | ((sel == 2) << `S1_RETSLOW) | ((i % 4) << `S1_WUT_LO));
            status(1);
            s = nDiv;
            kick(0);
            waitEnd(nRes + nSvc);
            bus(0, `SYSCTL1_OFS, 0);
            `CHK("stop bit", 0, rd[`S1_STOP])
            `CHK("warm", 1, endCyc - riseCyc >= warm[i] && endCyc - riseCyc <= warm[i] + 4)
            `CHK("osc", (sel == 0) ? 2'b10 : ((sel == 1) ? 2'b11 : 2'b01), oscWarm)
            `CHK("divider clear", 1, nDiv > s)
        end
        for (int m = 0; m < 3; m++)
        begin
            if (m == 0)
                bus(1, `SYSCTL1_OFS, 8'ha0);
            else
                bus(1, `SYSCTL2_OFS, (m == 1) ? 8'h90 : 8'h84);
            status((m == 0) ? 1 : m + 2);
            rst_n <= 1'b0;
            repeat (2) @(posedge mclk);
            rst_n <= 1'b1;
            @(posedge mclk);
            status(0);
            `CHK("osc", 2'b10, {highOscEnable, lowOscEnable})
        end
        for (int f = 0; f < 2; f++)
        begin
            bus(1, `INTCTL_OFS, f);
            bus(1, `SYSCTL2_OFS, 8'h90);
            status(3);
            `CHK("halts", 2'b11, {cpuHalt, watchdogHalt})
            s = nSvc;
            r = nRes;
            kick(1);
            waitEnd(s + r);
            bus(0, `SYSCTL2_OFS, 0);
            `CHK("idle bit", 0, rd[`S2_IDLE])
            `CHK("service", f, nSvc - s)
            `CHK("resume", 1 - f, nRes - r)
        end
        watchdogIrq <= 1'b1;
        bus(1, `SYSCTL2_OFS, 8'h90);
        status(0);
        watchdogIrq <= 1'b0;
        // Bit 0 master, 1 timebase enable, 2 timer enable, 3 latch-8 select
        for (int i = 0; i < 16; i++)
        begin
            bus(1, `INTCTL_OFS, i[0] | (i[1] << `IC_EFTB) | (i[3] << `IC_L8SEL));
            bus(1, `TBCTL_OFS, i[2] << `TB_EN);
            bus(1, `SYSCTL2_OFS, 8'h84);
            status(4);
            `CHK("gate", 1, peripheralClockGate)
            s = nSvc;
            r = nRes;
            b = nTb;
            kick(2);
            waitEnd(s + r);
            bus(0, `SYSCTL2_OFS, 0);
            `CHK("halt bit", 0, rd[`S2_GENERATOR_HALT_BIT])
            `CHK("timebase latch", i[2], nTb - b)
            `CHK("service", i == 7, nSvc - s)
            `CHK("resume", i != 7, nRes - r)
        end
        conclude();
    end
endmodule : tb
